// ==== dv/pt_pin_model.sv ====
module pt_pin_model (
   input wire logic mclk_i,
   input wire logic fire_i,
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] hold_r = 2'h0; // cycles left of the trigger pulse
   // one clean two-clock pulse per request, idle low so no stray edge
   always @(posedge mclk_i)
   begin
      hold_r <= fire_i ? 2'h2 : ((hold_r != 2'h0) ? hold_r - 2'h1 : 2'h0);
   end
   assign pin_o = (hold_r != 2'h0);
endmodule : pt_pin_model

// ==== dv/pt_timer_checker.sv ====
module pt_timer_checker
   import pt_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire pt_bus_req_t bus_i,
   input wire logic [7:0] rdata_o,
   input wire logic ext_clock_pin_i,
   input wire logic timer_output_pin_o,
   input wire logic timer_output_oe_o,
   input wire logic match_a_flag_o,
   input wire logic match_p_flag_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // ----------------------------
   // register read side
   // ----------------------------
   rdata_idle_a: assert property (!bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   hi_bits_zero_a: assert property (bus_i.rd && bus_i.addr inside {4'h1, 4'h3, 4'h5} |=> rdata_o[7:2] == 6'h00)
      else $error("unused high bits not zero");
   unmapped_zero_a: assert property (bus_i.rd && bus_i.addr > 4'h8 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   flag_read_a: assert property (bus_i.rd && bus_i.addr == 4'h8 |=> rdata_o[1:0] == {$past(match_p_flag_o), $past(match_a_flag_o)})
      else $error("flag read differs from flag outputs");
   // ----------------------------
   // flags, pin enable, reset
   // ----------------------------
   // flags are sticky: only a flag write may drop them
   flag_a_hold_a: assert property (match_a_flag_o && !(bus_i.wr && bus_i.addr == 4'h8) |=> match_a_flag_o)
      else $error("match a flag dropped without clear");
   flag_p_hold_a: assert property (match_p_flag_o && !(bus_i.wr && bus_i.addr == 4'h8) |=> match_p_flag_o)
      else $error("match p flag dropped without clear");
   oe_mode_a: assert property (bus_i.wr && bus_i.addr == 4'h7 |=> timer_output_oe_o == !$past(bus_i.wdata[6]))
      else $error("pin enable does not follow mode");
   reset_vals_a: assert property ($rose(rst_n_i) |-> !match_a_flag_o && !match_p_flag_o && !timer_output_pin_o)
      else $error("outputs not cleared by reset");
endmodule : pt_timer_checker

bind pt_timer pt_timer_checker u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .ext_clock_pin_i(ext_clock_pin_i), .timer_output_pin_o(timer_output_pin_o),
   .timer_output_oe_o(timer_output_oe_o), .match_a_flag_o(match_a_flag_o), .match_p_flag_o(match_p_flag_o));

// ==== dv/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import pt_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   pt_bus_req_t bus_i = '0;
   logic [7:0] rdata_o;
   logic ext_pin, pin, oe, fa, fp;
   logic fire = 1'b0; // trigger request to the pin model
   int n_fail = 0;
   int total_checks = 0;
   int seed = 74715;
   logic [7:0] v, r;
   logic [3:0] a;
   int n;
   logic [7:0] c_tab [5] = '{8'ha8, 8'hac, 8'h88, 8'h98, 8'ha9}; // pwm control cases
   int a_tab [5] = '{3, 3, 3, 3, 9}; // duty counts, last one saturates
   always #12.5 mclk_i = ~mclk_i;
   pt_timer u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .ext_clock_pin_i(ext_pin), .timer_output_pin_o(pin), .timer_output_oe_o(oe),
      .match_a_flag_o(fa), .match_p_flag_o(fp));
   pt_pin_model u_pin (.mclk_i(mclk_i), .fire_i(fire), .pin_o(ext_pin));
   // ----------------------------
   // helpers
   // ----------------------------
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task end_sim;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge mclk_i);
      bus_i <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      bus_i.wr <= 1'b0;
   endtask : wr
   // read data is only valid in the cycle after the strobe
   task rd(input logic [3:0] ad, output logic [7:0] d);
      @(posedge mclk_i);
      bus_i <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      bus_i.rd <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   // stop first so the mode change never hits a running counter
   task cfg(input logic [7:0] c1, input logic [7:0] ca, input logic [7:0] p, input logic [7:0] run);
      wr(4'h6, 8'h00);
      wr(4'h7, c1);
      wr(4'h2, ca);
      wr(4'h3, 8'h00);
      wr(4'h4, p);
      wr(4'h5, 8'h00);
      wr(4'h8, 8'h03);
      wr(4'h6, run);
   endtask : cfg
   task hi_cnt(input int cyc, output int h);
      h = 0;
      repeat (cyc)
      begin
         @(posedge mclk_i);
         #1;
         h += int'(pin === 1'b1);
      end
   endtask : hi_cnt
   // expected high cycles over a window of whole periods
   function automatic int pwm_hi(logic [7:0] c1, int ca, int p, int cyc);
      int act;
      act = (c1[5:4] == 2'b10) ? ((ca >= p) ? p : ca) * (cyc / p) : (c1[4] ? cyc : 0);
      return (c1[3] ^ c1[2]) ? act : cyc - act;
   endfunction : pwm_hi
   // ----------------------------
   // main sequence
   // ----------------------------
   initial
   begin
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         rd(4'(i), r);
         chk("reset value", r, 8'h00);
      end
      for (int i = 0; i < 12; i++)
      begin
         v = 8'($random(seed)) | 8'h01;
         a = 4'(i % 6);
         wr(a, v);
         rd(a, r);
         chk("reg readback", r, (a < 4'h2) ? 8'h00 : (a[0] ? (v & 8'h03) : v));
      end
      rd(4'hc, r);
      chk("unmapped read", r, 8'h00);
      // compare mode, clear on a: pin goes high, no p flag
      cfg(8'h21, 8'd10, 8'd3, 8'h08);
      repeat (40) @(posedge mclk_i);
      chk("a flag", fa, 1'b1);
      chk("p flag", fp, 1'b0);
      chk("pin high", pin, 1'b1);
      wr(4'h6, 8'h00);
      wr(4'h6, 8'h08);
      repeat (2) @(posedge mclk_i);
      #1;
      chk("pin initial", pin, 1'b0);
      // compare and timer modes, clear on p
      for (int m = 0; m < 2; m++)
      begin
         cfg(m ? 8'hf0 : 8'h30, 8'd3, 8'd5, 8'h08);
         repeat (30) @(posedge mclk_i);
         chk("both flags", {fa, fp}, 2'b11);
         chk("pin enable", oe, m ? 1'b0 : 1'b1);
         for (int k = 0; k < 6; k++)
         begin
            rd(4'h0, r);
            chk("count bound", r < 8'd5, 1'b1);
         end
      end
      // pwm waveforms over four whole periods of eight
      for (int i = 0; i < 5; i++)
      begin
         cfg(c_tab[i], 8'(a_tab[i]), 8'd8, 8'h08);
         repeat (20) @(posedge mclk_i);
         hi_cnt(32, n);
         chk("pwm high count", 8'(n), 8'(pwm_hi(c_tab[i], a_tab[i], 8, 32)));
         chk("pwm p flag", fp, 1'b1);
         chk("pwm a flag", fa, 8'(a_tab[i] < 8));
      end
      // single pulse started by the trigger pin
      cfg(8'hb8, 8'd6, 8'd0, 8'h00);
      @(posedge mclk_i);
      fire <= 1'b1;
      @(posedge mclk_i);
      fire <= 1'b0;
      hi_cnt(30, n);
      // run stands for the restart cycle plus counts 0 through compare_a
      chk("pulse width", 8'(n), 8'(6 + 2));
      rd(4'h6, r);
      chk("run cleared", r[3], 1'b0);
      chk("pulse a flag", fa, 1'b1);
      end_sim;
   end
   // hang guard, well beyond the roughly 640 cycles the tests take
   initial
   begin
      #200000;
      n_fail++;
      end_sim;
   end
endmodule : tb_top

// ==== rtl/pt_pkg.sv ====
package pt_pkg;
   // ---------------------------------------------
   // register map (byte offsets, our own choice)
   // ---------------------------------------------
   localparam logic [3:0] PT_CNT_LO_OFF = 4'h0;
   localparam logic [3:0] PT_CNT_HI_OFF = 4'h1;
   localparam logic [3:0] PT_CMPA_LO_OFF = 4'h2;
   localparam logic [3:0] PT_CMPA_HI_OFF = 4'h3;
   localparam logic [3:0] PT_PER_LO_OFF = 4'h4;
   localparam logic [3:0] PT_PER_HI_OFF = 4'h5;
   localparam logic [3:0] PT_CTRL0_OFF = 4'h6;
   localparam logic [3:0] PT_CTRL1_OFF = 4'h7;
   localparam logic [3:0] PT_FLAG_OFF = 4'h8;
   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int PT_RUN_BIT = 3;     // ctrl0: counter_run
   localparam int PT_EDGE_BIT = 0;    // ctrl0: ext edge select, 1 = falling
   localparam int PT_MODE_HI = 7;     // ctrl1: mode_select 7:6
   localparam int PT_FUNC_HI = 5;     // ctrl1: pin_function 5:4
   localparam int PT_INIT_BIT = 3;    // ctrl1: initial_level
   localparam int PT_INV_BIT = 2;     // ctrl1: output_invert
   localparam int PT_CLR_BIT = 0;     // ctrl1: clear_source
   localparam int PT_FA_BIT = 0;      // flags: match_a_flag
   localparam int PT_FP_BIT = 1;      // flags: match_p_flag
   localparam logic [7:0] PT_RST_BYTE = 8'h00;
   localparam logic [9:0] PT_CNT_RST = 10'h000;
   localparam logic [9:0] PT_CNT_MAX = 10'h3ff;
   // ---------------------------------------------
   // modes and pin functions
   // ---------------------------------------------
   typedef enum logic [1:0] {
      PT_MODE_CMP = 2'b00,
      PT_MODE_CAP = 2'b01,
      PT_MODE_PWM = 2'b10,
      PT_MODE_TMR = 2'b11
   } pt_mode_t;
   typedef enum logic [1:0] {
      PT_FN_00 = 2'b00,
      PT_FN_01 = 2'b01,
      PT_FN_10 = 2'b10,
      PT_FN_11 = 2'b11
   } pt_func_t;
   // register bus request bundle
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pt_bus_req_t;
endpackage : pt_pkg

// ==== rtl/pt_timer.sv ====
// Our own choices: the placing of the registers and the plain strobed port.
module pt_timer
   import pt_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire pt_bus_req_t bus_i,
   output logic [7:0] rdata_o,
   input wire logic ext_clock_pin_i,
   output logic timer_output_pin_o,
   output logic timer_output_oe_o,
   output logic match_a_flag_o,
   output logic match_p_flag_o
);
   // ---------------------------------------------
   // storage
   // ---------------------------------------------
   logic [9:0] count_r;          // the up-counter
   logic [9:0] cmpa_r;           // compare_a_value
   logic [9:0] per_r;            // period_value
   logic run_r;                  // counter_run
   logic run_d_r;                // last cycle's run, for edge
   logic edge_sel_r;             // ext clock active edge
   logic [7:0] ctrl1_r;          // mode, function, level, invert, clear
   logic fa_r;                   // match_a_flag
   logic fp_r;                   // match_p_flag
   logic pin_r;                  // compare-mode pin state
   logic pin_out_r;              // registered pin level
   logic ext_d_r;                // previous ext pin sample
   logic [7:0] rdata_r;
   pt_mode_t mode;
   pt_func_t func;
   logic run_rise;
   logic match_a;
   logic match_p;
   logic clr_cnt;
   logic ext_edge;
   logic cmp_like;
   logic pwm_mode;
   logic sp_mode;
   logic fa_set;
   logic fp_set;
   logic wr_ctrl0;
   logic wr_flag;
   logic wr_cmpa_lo;             // compare_a low byte write
   logic wr_cmpa_hi;             // compare_a high bits write
   logic wr_per_lo;              // period low byte write
   logic wr_per_hi;              // period high bits write
   logic wr_ctrl1;               // control byte write

   // ---------------------------------------------
   // mode and bus strobe decode
   // ---------------------------------------------
   // mode bits should only change while stopped; nothing here guards it
   assign mode = pt_mode_t'(ctrl1_r[PT_MODE_HI -: 2]);
   assign func = pt_func_t'(ctrl1_r[PT_FUNC_HI -: 2]);
   assign cmp_like = (mode == PT_MODE_CMP) || (mode == PT_MODE_TMR);
   assign pwm_mode = (mode == PT_MODE_PWM) && (func != PT_FN_11);
   assign sp_mode = (mode == PT_MODE_PWM) && (func == PT_FN_11);
   assign run_rise = run_r && !run_d_r;
   assign wr_ctrl0 = bus_i.wr && (bus_i.addr == PT_CTRL0_OFF);
   assign wr_flag = bus_i.wr && (bus_i.addr == PT_FLAG_OFF);
   assign wr_cmpa_lo = bus_i.wr && (bus_i.addr == PT_CMPA_LO_OFF);
   assign wr_cmpa_hi = bus_i.wr && (bus_i.addr == PT_CMPA_HI_OFF);
   assign wr_per_lo = bus_i.wr && (bus_i.addr == PT_PER_LO_OFF);
   assign wr_per_hi = bus_i.wr && (bus_i.addr == PT_PER_HI_OFF);
   assign wr_ctrl1 = bus_i.wr && (bus_i.addr == PT_CTRL1_OFF);
   // ext pin is sampled synchronously; edge select picks rising or falling
   assign ext_edge = edge_sel_r ? (ext_d_r && !ext_clock_pin_i) : (!ext_d_r && ext_clock_pin_i);

   // ---------------------------------------------
   // comparators
   // ---------------------------------------------
   // a match is taken on the counter value while running; in compare
   // mode a zero period means the overflow point 3ff ends the cycle;
   // the restart cycle still shows the old residual count, so matches
   // are masked there, otherwise a pulse that stopped on compare_a
   // would end again the moment it is retriggered
   always_comb
   begin
      match_a = run_r && !run_rise && (count_r == cmpa_r);
      if (per_r == PT_CNT_RST)
      begin
         match_p = run_r && !run_rise && (count_r == PT_CNT_MAX);
      end
      else
      begin
         match_p = run_r && !run_rise && (count_r == per_r - 10'h001);
      end
   end

   // counter clear selection per mode
   always_comb
   begin
      if (cmp_like)
      begin
         clr_cnt = ctrl1_r[PT_CLR_BIT] ? match_a : match_p;
      end
      else if (pwm_mode)
      begin
         clr_cnt = match_p;
      end
      else
      begin
         clr_cnt = 1'b0;
      end
   end

   // flag sources
   always_comb
   begin
      fa_set = match_a;
      if (cmp_like && ctrl1_r[PT_CLR_BIT])
      begin
         fp_set = 1'b0;
      end
      else if (sp_mode)
      begin
         fp_set = 1'b0;
      end
      else
      begin
         fp_set = match_p;
      end
   end

   // ---------------------------------------------
   // counter: zero on run rise, hold when stopped
   // ---------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         count_r <= PT_CNT_RST;
      end
      else if (run_rise)
      begin
         count_r <= PT_CNT_RST;
      end
      else if (run_r)
      begin
         if (clr_cnt)
         begin
            count_r <= PT_CNT_RST;
         end
         else if (!(sp_mode && match_a))
         begin
            count_r <= count_r + 10'h001;
         end
      end
   end

   // ---------------------------------------------
   // run control: software, ext trigger, auto stop
   // ---------------------------------------------
   // set beats the automatic stop, but a trigger in the same cycle gives no restart: count holds at compare_a and run drops a cycle later
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         run_r <= 1'b0;
         edge_sel_r <= 1'b0;
      end
      else if (wr_ctrl0)
      begin
         run_r <= bus_i.wdata[PT_RUN_BIT];
         edge_sel_r <= bus_i.wdata[PT_EDGE_BIT];
      end
      else if (sp_mode && ext_edge)
      begin
         run_r <= 1'b1;
      end
      else if (sp_mode && match_a)
      begin
         run_r <= 1'b0;
      end
   end

   // last cycle's run, the reference for the rising edge
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         run_d_r <= 1'b0;
      end
      else
      begin
         run_d_r <= run_r;
      end
   end

   // previous trigger pin level; reset low so an idle-low pin gives
   // no false edge once reset lifts
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         ext_d_r <= 1'b0;
      end
      else
      begin
         ext_d_r <= ext_clock_pin_i;
      end
   end

   // ---------------------------------------------
   // configuration registers
   // ---------------------------------------------
   // software must not leave compare_a at zero in compare mode; not checked
   // the two halves load on their own, so a running timer sees a half
   // updated value until the other half is written; stop it first when that matters
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         cmpa_r <= PT_CNT_RST;
      end
      else if (wr_cmpa_lo)
      begin
         cmpa_r[7:0] <= bus_i.wdata;
      end
      else if (wr_cmpa_hi)
      begin
         cmpa_r[9:8] <= bus_i.wdata[1:0];
      end
   end

   // period_value halves, loaded the same way
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         per_r <= PT_CNT_RST;
      end
      else if (wr_per_lo)
      begin
         per_r[7:0] <= bus_i.wdata;
      end
      else if (wr_per_hi)
      begin
         per_r[9:8] <= bus_i.wdata[1:0];
      end
   end

   // control byte; the counter bytes have no write path at all
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         ctrl1_r <= PT_RST_BYTE;
      end
      else if (wr_ctrl1)
      begin
         ctrl1_r <= bus_i.wdata;
      end
   end

   // ---------------------------------------------
   // match flags: set wins over write-one-to-clear
   // ---------------------------------------------
   // match_a_flag: a new match beats a clear in the same cycle
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         fa_r <= 1'b0;
      end
      else
      begin
         fa_r <= fa_set || (fa_r && !(wr_flag && bus_i.wdata[PT_FA_BIT]));
      end
   end

   // match_p_flag: same rule, so no match is ever lost to software
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         fp_r <= 1'b0;
      end
      else
      begin
         fp_r <= fp_set || (fp_r && !(wr_flag && bus_i.wdata[PT_FP_BIT]));
      end
   end

   // ---------------------------------------------
   // compare-mode pin state
   // ---------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         pin_r <= 1'b0;
      end
      else if (run_rise)
      begin
         pin_r <= ctrl1_r[PT_INIT_BIT];
      end
      else if (mode == PT_MODE_CMP && match_a)
      begin
         case (func)
            PT_FN_01: pin_r <= 1'b0;
            PT_FN_10: pin_r <= 1'b1;
            PT_FN_11: pin_r <= !pin_r;
            default: pin_r <= pin_r;                        // no change
         endcase
      end
   end

   // ---------------------------------------------
   // output level per mode, registered
   // ---------------------------------------------
   // pwm active while count below compare_a; compare_a at or above the
   // period keeps it active all cycle, giving 100% duty
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         pin_out_r <= 1'b0;
      end
      else
      begin
         case (mode)
            PT_MODE_CMP: pin_out_r <= pin_r ^ ctrl1_r[PT_INV_BIT];
            PT_MODE_PWM:
            begin
               if (sp_mode)
               begin
                  // pulse active for as long as run stays high
                  pin_out_r <= (run_r ~^ ctrl1_r[PT_INIT_BIT]) ^ ctrl1_r[PT_INV_BIT];
               end
               else if (func == PT_FN_10)
               begin
                  pin_out_r <= ((run_r && count_r < cmpa_r) ~^ ctrl1_r[PT_INIT_BIT])
                     ^ ctrl1_r[PT_INV_BIT];
               end
               else
               begin
                  pin_out_r <= (func[0] ~^ ctrl1_r[PT_INIT_BIT]) ^ ctrl1_r[PT_INV_BIT];
               end
            end
            default: pin_out_r <= 1'b0;
         endcase
      end
   end

   // ---------------------------------------------
   // register read port, data one cycle later
   // ---------------------------------------------
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         rdata_r <= PT_RST_BYTE;
      end
      else if (bus_i.rd)
      begin
         case (bus_i.addr)
            PT_CNT_LO_OFF: rdata_r <= count_r[7:0];
            PT_CNT_HI_OFF: rdata_r <= {6'h00, count_r[9:8]};
            PT_CMPA_LO_OFF: rdata_r <= cmpa_r[7:0];
            PT_CMPA_HI_OFF: rdata_r <= {6'h00, cmpa_r[9:8]};
            PT_PER_LO_OFF: rdata_r <= per_r[7:0];
            PT_PER_HI_OFF: rdata_r <= {6'h00, per_r[9:8]};
            PT_CTRL0_OFF: rdata_r <= {4'h0, run_r, 2'b00, edge_sel_r};
            PT_CTRL1_OFF: rdata_r <= ctrl1_r;
            PT_FLAG_OFF: rdata_r <= {6'h00, fp_r, fa_r};
            default: rdata_r <= PT_RST_BYTE;                 // unmapped reads zero
         endcase
      end
      else
      begin
         rdata_r <= PT_RST_BYTE;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   // the enable comes from the mode bits alone, so timer mode hands
   // the pin back as soon as the mode is written
   assign rdata_o = rdata_r;
   assign timer_output_pin_o = pin_out_r;
   assign timer_output_oe_o = (mode == PT_MODE_CMP) || (mode == PT_MODE_PWM);
   assign match_a_flag_o = fa_r;
   assign match_p_flag_o = fp_r;
endmodule : pt_timer
